// File: src/can_bit_timing_pkg.sv
// Constants and types shared by the CAN bit timing configuration block
package can_bit_timing_pkg;
  localparam logic [7:0] ADDR_CFG_A = 8'h2A;
  localparam logic [7:0] ADDR_CFG_B = 8'h29;
  localparam logic [7:0] ADDR_CFG_C = 8'h28;
  localparam logic [7:0] RESET_CFG_A = 8'h00;
  localparam logic [7:0] RESET_CFG_B = 8'h00;
  localparam logic [7:0] RESET_CFG_C = 8'h00;
  localparam int PRESCALER_LSB = 0;
  localparam int PRESCALER_W = 6;
  localparam int JUMP_LSB = 6;
  localparam int JUMP_W = 2;
  localparam int PROP_LSB = 0;
  localparam int PH1_LSB = 3;
  localparam int PH2_LSB = 0;
  localparam int SEG_W = 3;
  localparam int TRIPLE_BIT = 6;
  localparam int PH2_SRC_BIT = 7;
  localparam int WAKE_BIT = 6;
  localparam int SOF_BIT = 7;
  localparam logic [7:0] CFG_C_IMPL_MASK = 8'hC7;
  localparam logic [3:0] SYNC_QUANTA = 4'h1;
  localparam logic [3:0] IPT_QUANTA = 4'h2;
  localparam int LEN_W = 4;
  typedef enum logic [1:0] {
    SEG_SYNC = 2'b00,
    SEG_PROP = 2'b01,
    SEG_PH1 = 2'b11,
    SEG_PH2 = 2'b10
  } seg_state_t;
endpackage : can_bit_timing_pkg

// File: src/bit_quantum_if.sv
// Quantum timing and sampling signals between the bit timing modules
`timescale 1ns/1ps
`default_nettype none
interface bit_quantum_if;
  logic [can_bit_timing_pkg::PRESCALER_W-1:0] prescale;
  logic restart;
  logic tq_tick;
  logic half_tick;
  logic rx;
  logic triple;
  logic sample_strobe;
  logic sampled_bit;
  modport gen (input prescale, input restart, output tq_tick, output half_tick);
  modport smp (input tq_tick, input half_tick, input rx, input triple, input sample_strobe, output sampled_bit);
  modport core (output prescale, output restart, input tq_tick, input half_tick, output rx, output triple,
                output sample_strobe, input sampled_bit);
endinterface : bit_quantum_if
`default_nettype wire

// File: src/quantum_prescaler.sv
// Time quantum generator: one quantum every 2*(prescale+1) clocks
`timescale 1ns/1ps
`default_nettype none
module quantum_prescaler (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  bit_quantum_if.gen tq
);
  localparam int CNT_W = can_bit_timing_pkg::PRESCALER_W + 1;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] half_end;
  logic [CNT_W-1:0] full_end;

  assign half_end = {1'b0, tq.prescale};
  assign full_end = {tq.prescale, 1'b1};
  assign tq.half_tick = (count_q == half_end) && !tq.restart;
  assign tq.tq_tick = (count_q == full_end) && !tq.restart;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      count_q <= '0;
    end else if (tq.restart || count_q == full_end) begin
      count_q <= '0;
    end else begin
      count_q <= count_q + 1'b1;
    end
  end
endmodule : quantum_prescaler
`default_nettype wire

// File: src/bus_sampler.sv
// Bus sampler: single sample or majority of three half-quantum samples
`timescale 1ns/1ps
`default_nettype none
module bus_sampler (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  bit_quantum_if.smp tq
);
  logic [1:0] hist_q;
  logic bit_q;
  logic majority;

  // Recessive history so a first frame after reset does not vote dominant
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hist_q <= 2'h3;
    end else if (tq.half_tick || tq.tq_tick) begin
      hist_q <= {hist_q[0], tq.rx};
    end
  end

  assign majority = (hist_q[1] & hist_q[0]) | (hist_q[1] & tq.rx) | (hist_q[0] & tq.rx);

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bit_q <= 1'b1;
    end else if (tq.sample_strobe) begin
      bit_q <= tq.triple ? majority : tq.rx;
    end
  end

  assign tq.sampled_bit = bit_q;
endmodule : bus_sampler
`default_nettype wire

// File: src/can_bit_timing_config.sv
// CAN bit timing configuration registers and nominal bit time sequencer
// Summary of operation
// - Timing registers written only in configuration mode
// - Quantum is two times prescaler plus one
// - Jump width codes give one to four
// - Propagation segment is field plus one quanta
// - First phase is field plus one quanta
// - Triple sampling takes majority of three samples
// - Single sample at end of first phase
// - Source bit set: phase two from field
// - Source bit clear: max of phase one, two
// - Source bit clear: phase two field ignored
// - Source bit set: phase two is field plus one quanta
// - Start-of-frame bit steers clock output when enabled
// - Wake-up filter follows its enable bit
// - Unimplemented third register bits read zero
// - Synchronization segment is always one quantum
// - Bit is sync, propagation, phase one, two
// - Resync adjusts phases by at most jump width
`timescale 1ns/1ps
`default_nettype none
module can_bit_timing_config (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_write,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_read,
  output logic [7:0] o_reg_rdata,
  input wire logic i_config_mode,
  input wire logic i_clock_output_enable,
  input wire logic i_bus_receive_pin,
  input wire logic i_bus_idle,
  input wire logic i_transmitting,
  output logic o_clock_output_sof_select,
  output logic o_clock_output_divided_select,
  output logic o_wakeup_glitch_filter_enable,
  output logic o_quantum_tick,
  output logic o_bit_start,
  output logic o_sample_point,
  output logic o_sampled_bit,
  output logic [1:0] o_segment
);
  localparam int LW = can_bit_timing_pkg::LEN_W;

  logic [7:0] cfg_a_q;
  logic [7:0] cfg_b_q;
  logic [7:0] cfg_c_q;
  logic [7:0] rdata_q;

  can_bit_timing_pkg::seg_state_t seg_q;
  can_bit_timing_pkg::seg_state_t seg_d;
  logic [LW-1:0] cnt_q;
  logic [LW-1:0] cnt_d;
  logic [LW-1:0] stretch_q;
  logic [LW-1:0] shrink_q;
  logic synced_q;
  logic rx_prev_q;
  logic end_bit_q;

  logic [LW-1:0] prop_len;
  logic [LW-1:0] ph1_len;
  logic [LW-1:0] ph1_base;
  logic [LW-1:0] ph2_len;
  logic [LW-1:0] ph2_eff;
  logic [LW-1:0] seg_len;
  logic [LW-1:0] jump;
  logic [LW-1:0] pos_err;
  logic [LW:0] pos_sum;
  logic [LW-1:0] neg_err;
  logic fall_edge;
  logic hard_sync;
  logic resync_edge;
  logic seg_done;

  bit_quantum_if tq ();

  quantum_prescaler u_prescaler (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .tq(tq)
  );

  bus_sampler u_sampler (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .tq(tq)
  );

  // Field plus one, widened to the length counter
  function automatic logic [LW-1:0] plus_one(input logic [2:0] f);
    plus_one = {1'b0, f} + 4'h1;
  endfunction : plus_one

  // Smaller of two lengths, used to bound the phase one lengthening of a resync
  function automatic logic [LW-1:0] min_len(input logic [LW-1:0] a, input logic [LW-1:0] b);
    min_len = (a < b) ? a : b;
  endfunction : min_len

  // Register writes; the bit timing stays stable while the bus runs
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_a_q <= can_bit_timing_pkg::RESET_CFG_A;
    end else if (i_reg_write && i_config_mode && i_reg_addr == can_bit_timing_pkg::ADDR_CFG_A) begin
      cfg_a_q <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_b_q <= can_bit_timing_pkg::RESET_CFG_B;
    end else if (i_reg_write && i_config_mode && i_reg_addr == can_bit_timing_pkg::ADDR_CFG_B) begin
      cfg_b_q <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_c_q <= can_bit_timing_pkg::RESET_CFG_C;
    end else if (i_reg_write && i_config_mode && i_reg_addr == can_bit_timing_pkg::ADDR_CFG_C) begin
      cfg_c_q <= i_reg_wdata & can_bit_timing_pkg::CFG_C_IMPL_MASK;
    end
  end

  // Read data registered one cycle after the read strobe; unmapped reads zero
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_q <= 8'h00;
    end else if (i_reg_read) begin
      case (i_reg_addr)
        can_bit_timing_pkg::ADDR_CFG_A: rdata_q <= cfg_a_q;
        can_bit_timing_pkg::ADDR_CFG_B: rdata_q <= cfg_b_q;
        can_bit_timing_pkg::ADDR_CFG_C: rdata_q <= cfg_c_q & can_bit_timing_pkg::CFG_C_IMPL_MASK;
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  assign o_reg_rdata = rdata_q;

  // Pin function selects
  assign o_clock_output_sof_select = i_clock_output_enable & cfg_c_q[can_bit_timing_pkg::SOF_BIT];
  assign o_clock_output_divided_select = i_clock_output_enable & ~cfg_c_q[can_bit_timing_pkg::SOF_BIT];
  assign o_wakeup_glitch_filter_enable = cfg_c_q[can_bit_timing_pkg::WAKE_BIT];

  // Segment lengths in quanta
  assign tq.prescale = cfg_a_q[can_bit_timing_pkg::PRESCALER_LSB +: can_bit_timing_pkg::PRESCALER_W];
  assign jump = {2'b00, cfg_a_q[can_bit_timing_pkg::JUMP_LSB +: can_bit_timing_pkg::JUMP_W]} + 4'h1;
  assign prop_len = plus_one(cfg_b_q[can_bit_timing_pkg::PROP_LSB +: can_bit_timing_pkg::SEG_W]);
  assign ph1_base = plus_one(cfg_b_q[can_bit_timing_pkg::PH1_LSB +: can_bit_timing_pkg::SEG_W]);
  assign ph1_len = ph1_base + stretch_q;

  // Phase two ignores its own field unless the source bit selects it
  always_comb begin
    if (cfg_b_q[can_bit_timing_pkg::PH2_SRC_BIT]) begin
      ph2_len = plus_one(cfg_c_q[can_bit_timing_pkg::PH2_LSB +: can_bit_timing_pkg::SEG_W]);
    end else if (ph1_base > can_bit_timing_pkg::IPT_QUANTA) begin
      ph2_len = ph1_base;
    end else begin
      ph2_len = can_bit_timing_pkg::IPT_QUANTA;
    end
  end

  // A too-short phase two is software's fault; never let shortening reach zero
  assign ph2_eff = (ph2_len > shrink_q) ? ph2_len - shrink_q : 4'h1;

  always_comb begin
    case (seg_q)
      can_bit_timing_pkg::SEG_SYNC: seg_len = can_bit_timing_pkg::SYNC_QUANTA;
      can_bit_timing_pkg::SEG_PROP: seg_len = prop_len;
      can_bit_timing_pkg::SEG_PH1: seg_len = ph1_len;
      can_bit_timing_pkg::SEG_PH2: seg_len = ph2_eff;
      default: seg_len = can_bit_timing_pkg::SYNC_QUANTA;
    endcase
  end

  assign seg_done = tq.tq_tick && (cnt_q + 4'h1 >= seg_len);

  // Edge handling: only recessive-to-dominant after a recessive sample counts
  assign tq.rx = i_bus_receive_pin;
  assign fall_edge = rx_prev_q && !i_bus_receive_pin && tq.sampled_bit;
  assign hard_sync = fall_edge && i_bus_idle;
  assign resync_edge = fall_edge && !i_bus_idle && !synced_q;
  assign tq.restart = hard_sync;

  // Phase error in quanta from the end of sync, or remaining in phase two
  // Saturate so a late phase one edge never wraps to a tiny error
  assign pos_sum = {1'b0, prop_len} + {1'b0, cnt_q} + 5'h01;
  assign pos_err = (seg_q == can_bit_timing_pkg::SEG_PROP) ? cnt_q + 4'h1 :
                   (pos_sum[LW] ? 4'hF : pos_sum[LW-1:0]);
  assign neg_err = ph2_eff - cnt_q;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_prev_q <= 1'b1;
    end else begin
      rx_prev_q <= i_bus_receive_pin;
    end
  end

  // Bit sequencer, sync then propagation then phase one then phase two
  always_comb begin
    seg_d = seg_q;
    cnt_d = cnt_q;
    if (hard_sync) begin
      seg_d = can_bit_timing_pkg::SEG_SYNC;
      cnt_d = '0;
    end else if (end_bit_q && tq.tq_tick) begin
      seg_d = can_bit_timing_pkg::SEG_SYNC;
      cnt_d = '0;
    end else if (seg_done) begin
      cnt_d = '0;
      case (seg_q)
        can_bit_timing_pkg::SEG_SYNC: seg_d = can_bit_timing_pkg::SEG_PROP;
        can_bit_timing_pkg::SEG_PROP: seg_d = can_bit_timing_pkg::SEG_PH1;
        can_bit_timing_pkg::SEG_PH1: seg_d = can_bit_timing_pkg::SEG_PH2;
        can_bit_timing_pkg::SEG_PH2: seg_d = can_bit_timing_pkg::SEG_SYNC;
        default: seg_d = can_bit_timing_pkg::SEG_SYNC;
      endcase
    end else if (tq.tq_tick) begin
      cnt_d = cnt_q + 4'h1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      seg_q <= can_bit_timing_pkg::SEG_SYNC;
      cnt_q <= '0;
    end else begin
      seg_q <= seg_d;
      cnt_q <= cnt_d;
    end
  end

  // One synchronization per bit; cleared as each new bit begins
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      synced_q <= 1'b0;
    end else if (hard_sync || resync_edge) begin
      synced_q <= 1'b1;
    end else if (seg_d == can_bit_timing_pkg::SEG_SYNC && seg_q != can_bit_timing_pkg::SEG_SYNC) begin
      synced_q <= 1'b0;
    end
  end

  // Early edge lengthens phase one; a transmitter never does this
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stretch_q <= '0;
    end else if (hard_sync || seg_d == can_bit_timing_pkg::SEG_SYNC) begin
      stretch_q <= '0;
    end else if (resync_edge && !i_transmitting &&
                 (seg_q == can_bit_timing_pkg::SEG_PROP || seg_q == can_bit_timing_pkg::SEG_PH1)) begin
      stretch_q <= min_len(pos_err, jump);
    end
  end

  // Late edge shortens phase two, or ends the bit if within the jump width
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      shrink_q <= '0;
      end_bit_q <= 1'b0;
    end else if (hard_sync || seg_d == can_bit_timing_pkg::SEG_SYNC) begin
      shrink_q <= '0;
      end_bit_q <= 1'b0;
    end else if (resync_edge && seg_q == can_bit_timing_pkg::SEG_PH2) begin
      if (neg_err <= jump) begin
        end_bit_q <= 1'b1;
      end else begin
        shrink_q <= jump;
      end
    end
  end

  // Sample point is the quantum that closes phase one
  assign tq.sample_strobe = seg_done && seg_q == can_bit_timing_pkg::SEG_PH1 && !hard_sync;
  assign tq.triple = cfg_b_q[can_bit_timing_pkg::TRIPLE_BIT];

  assign o_quantum_tick = tq.tq_tick;
  assign o_sample_point = tq.sample_strobe;
  assign o_bit_start = (seg_d == can_bit_timing_pkg::SEG_SYNC) && (seg_q != can_bit_timing_pkg::SEG_SYNC || hard_sync);
  assign o_sampled_bit = tq.sampled_bit;
  assign o_segment = seg_q;
endmodule : can_bit_timing_config
`default_nettype wire

// File: tb/can_bit_timing_config_properties.sv
// Port checker for the CAN bit timing configuration block
`timescale 1ns/1ps
`default_nettype none
module can_bit_timing_checker (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_write,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_read,
  input wire logic [7:0] o_reg_rdata,
  input wire logic i_config_mode,
  input wire logic i_clock_output_enable,
  input wire logic i_bus_receive_pin,
  input wire logic o_clock_output_sof_select,
  input wire logic o_clock_output_divided_select,
  input wire logic o_wakeup_glitch_filter_enable,
  input wire logic o_quantum_tick,
  input wire logic o_bit_start,
  input wire logic o_sample_point,
  input wire logic o_sampled_bit,
  input wire logic [1:0] o_segment
);
  localparam logic [1:0] SYNC = can_bit_timing_pkg::SEG_SYNC;
  localparam logic [1:0] PROP = can_bit_timing_pkg::SEG_PROP;
  localparam logic [1:0] PH1 = can_bit_timing_pkg::SEG_PH1;
  localparam logic [1:0] PH2 = can_bit_timing_pkg::SEG_PH2;
  logic [7:0] a_q, b_q, c_q, rd_q, gap_q, lim;
  logic [3:0] cnt_q;
  logic [1:0] seg_q;
  logic dirty_q, wr;
  assign wr = i_reg_write && i_config_mode;
  assign lim = {1'b0, a_q[5:0], 1'b1};
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  // Shadow registers follow accepted writes only
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      a_q <= 8'h00;
      b_q <= 8'h00;
      c_q <= 8'h00;
    end else if (wr) begin
      if (i_reg_addr == can_bit_timing_pkg::ADDR_CFG_A) a_q <= i_reg_wdata;
      if (i_reg_addr == can_bit_timing_pkg::ADDR_CFG_B) b_q <= i_reg_wdata;
      if (i_reg_addr == can_bit_timing_pkg::ADDR_CFG_C) c_q <= i_reg_wdata & can_bit_timing_pkg::CFG_C_IMPL_MASK;
    end
  end
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) rd_q <= 8'h00;
    else if (i_reg_read) rd_q <= (i_reg_addr == can_bit_timing_pkg::ADDR_CFG_A) ? a_q :
                                 (i_reg_addr == can_bit_timing_pkg::ADDR_CFG_B) ? b_q :
                                 (i_reg_addr == can_bit_timing_pkg::ADDR_CFG_C) ? c_q : 8'h00;
  end
  // A write mixes old and new timing, so counts are trusted again only after the next bit start
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      gap_q <= 8'h00;
      dirty_q <= 1'b0;
      seg_q <= SYNC;
      cnt_q <= 4'h0;
    end else begin
      gap_q <= (o_quantum_tick || o_bit_start) ? 8'h00 : gap_q + 8'h01;
      dirty_q <= wr || (dirty_q && !o_bit_start);
      seg_q <= o_segment;
      cnt_q <= (o_segment != seg_q || o_bit_start) ? 4'h0 : cnt_q + {3'h0, o_quantum_tick};
    end
  end
  property p_tick_period;
    !dirty_q |-> gap_q <= lim && o_quantum_tick == (gap_q == lim);
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("Quantum tick spacing wrong");
  property p_read_back;
    o_reg_rdata == rd_q;
  endproperty
  a_read_back: assert property (p_read_back) else $error("Read data wrong");
  property p_clock_select;
    o_clock_output_sof_select == (i_clock_output_enable && c_q[7]) &&
    o_clock_output_divided_select == (i_clock_output_enable && !c_q[7]);
  endproperty
  a_clock_select: assert property (p_clock_select) else $error("Clock output select wrong");
  property p_wake;
    o_wakeup_glitch_filter_enable == c_q[can_bit_timing_pkg::WAKE_BIT];
  endproperty
  a_wake: assert property (p_wake) else $error("Wake filter enable wrong");
  property p_sync_len;
    seg_q == SYNC && o_segment == PROP |-> cnt_q == can_bit_timing_pkg::SYNC_QUANTA;
  endproperty
  a_sync_len: assert property (p_sync_len) else $error("Sync segment length wrong");
  property p_prop_len;
    seg_q == PROP && o_segment == PH1 && !dirty_q |-> cnt_q == {1'b0, b_q[2:0]} + 4'h1;
  endproperty
  a_prop_len: assert property (p_prop_len) else $error("Propagation length wrong");
  property p_seg_order;
    o_segment != seg_q |-> $past(o_quantum_tick) && (o_segment == SYNC || {seg_q, o_segment} inside {4'h1, 4'h7, 4'hE});
  endproperty
  a_seg_order: assert property (p_seg_order) else $error("Segment order wrong");
  property p_sample_end;
    o_sample_point |-> o_quantum_tick && o_segment == PH1 ##1 o_segment == PH2;
  endproperty
  a_sample_end: assert property (p_sample_end) else $error("Sample point misplaced");
  property p_single;
    o_sample_point && !b_q[can_bit_timing_pkg::TRIPLE_BIT] && !dirty_q |=> o_sampled_bit == $past(i_bus_receive_pin);
  endproperty
  a_single: assert property (p_single) else $error("Single sample wrong");
  cover property (o_sample_point && b_q[can_bit_timing_pkg::TRIPLE_BIT]);
  cover property (o_bit_start && b_q[can_bit_timing_pkg::PH2_SRC_BIT]);
  cover property (i_reg_write && !i_config_mode);
endmodule : can_bit_timing_checker
`default_nettype wire

// File: tb/cfg_host_model.sv
// Host model that writes and reads the timing registers
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
  input wire logic i_core_clk,
  input wire logic [7:0] i_reg_rdata,
  output logic [7:0] o_reg_addr,
  output logic o_reg_write,
  output logic [7:0] o_reg_wdata,
  output logic o_reg_read
);
  initial begin
    o_reg_addr = 8'h00;
    o_reg_write = 1'b0;
    o_reg_wdata = 8'h00;
    o_reg_read = 1'b0;
  end
  // Entered at a falling edge; each request stands for one rising edge
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] d;
    d = data;
    if (addr == can_bit_timing_pkg::ADDR_CFG_C && d[2:0] == 3'h0) d[2:0] = 3'h1;
    o_reg_addr = addr;
    o_reg_wdata = d;
    o_reg_write = 1'b1;
    @(negedge i_core_clk);
    o_reg_write = 1'b0;
    o_reg_wdata = ~d;
    // Idle cycle so a following request never re-raises a strobe in the same step
    @(negedge i_core_clk);
  endtask : write_reg
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    o_reg_addr = addr;
    o_reg_read = 1'b1;
    @(negedge i_core_clk);
    o_reg_read = 1'b0;
    data = i_reg_rdata;
    @(negedge i_core_clk);
  endtask : read_reg
endmodule : cfg_host_model
`default_nettype wire

// File: tb/can_bit_timing_config_bench.sv
// Self-checking bench for the CAN bit timing configuration block
`timescale 1ns/1ps
`default_nettype none
module can_bit_timing_config_bench;
  localparam int LIMIT = 20000;
  // Config mode, address, write data, expected read-back
  localparam logic [24:0] ROWS [6] = '{{1'b1, 8'h2A, 8'hC5, 8'hC5}, {1'b1, 8'h29, 8'h9A, 8'h9A},
    {1'b1, 8'h28, 8'hFF, 8'hC7}, {1'b0, 8'h2A, 8'h00, 8'hC5}, {1'b0, 8'h28, 8'h01, 8'hC7},
    {1'b1, 8'h27, 8'h55, 8'h00}};
  logic i_core_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic cm = 1'b1;
  logic clk_en = 1'b0;
  logic rx = 1'b1;
  logic [7:0] addr, wdata, rdata, got;
  logic wr, rd, sof_sel, div_sel, wake, tick, bstart, spoint, sbit;
  logic [1:0] seg;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  always #20 i_core_clk = ~i_core_clk;
  cfg_host_model host_u (.i_core_clk(i_core_clk), .i_reg_rdata(rdata), .o_reg_addr(addr), .o_reg_write(wr),
    .o_reg_wdata(wdata), .o_reg_read(rd));
  // Positive resync is kept out by holding transmit high, so phase one lengths stay nominal
  can_bit_timing_config dut_u (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_reg_addr(addr),
    .i_reg_write(wr), .i_reg_wdata(wdata), .i_reg_read(rd), .o_reg_rdata(rdata), .i_config_mode(cm),
    .i_clock_output_enable(clk_en), .i_bus_receive_pin(rx), .i_bus_idle(1'b0), .i_transmitting(1'b1),
    .o_clock_output_sof_select(sof_sel), .o_clock_output_divided_select(div_sel),
    .o_wakeup_glitch_filter_enable(wake), .o_quantum_tick(tick), .o_bit_start(bstart),
    .o_sample_point(spoint), .o_sampled_bit(sbit), .o_segment(seg));
  task automatic check_val(input logic [7:0] got_v, input logic [7:0] exp_v, input string what);
    comparisons++;
    if (got_v !== exp_v) begin
      fail_count++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got_v, exp_v);
    end
  endtask : check_val
  task automatic check_cnt(input int got_v, input int exp_v, input string what);
    comparisons++;
    if (got_v != exp_v) begin
      fail_count++;
      $display("[ERR] %0t %s: got %0d expected %0d", $time, what, got_v, exp_v);
    end
  endtask : check_cnt
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      $display("[ERR] %0t run did not finish", $time);
      complete_run();
    end
  end
  // Leaves the bench at the falling edge just after a bit start pulse
  task automatic wait_start();
    int k;
    for (k = 0; k < 2000 && bstart !== 1'b1; k++) @(negedge i_core_clk);
    @(negedge i_core_clk);
  endtask : wait_start
  task automatic timing_case(input logic m, input logic [7:0] a, b, c, input int ep, e1, e2, tq);
    int n[4];
    int clks;
    int k;
    cm = m;
    host_u.write_reg(8'h2A, a);
    host_u.write_reg(8'h29, b);
    host_u.write_reg(8'h28, c);
    cm = 1'b1;
    repeat (2) wait_start();
    n = '{0, 0, 0, 0};
    clks = 0;
    for (k = 0; k < 2000; k++) begin
      clks++;
      n[seg] += int'(tick);
      if (bstart === 1'b1) break;
      @(negedge i_core_clk);
    end
    check_cnt(clks, tq * (1 + ep + e1 + e2), "bit length");
    check_cnt(n[0], 1, "sync quanta");
    check_cnt(n[1], ep, "prop quanta");
    check_cnt(n[3], e1, "phase one quanta");
    check_cnt(n[2], e2, "phase two quanta");
    $display("timing case done");
  endtask : timing_case
  // A one-clock low pulse at the sample point outvoted only when three samples are taken
  task automatic sample_case(input logic triple);
    int k;
    host_u.write_reg(8'h29, {1'b0, triple, 6'h00});
    repeat (2) wait_start();
    for (k = 0; k < 2000 && !(seg === 2'b11 && tick === 1'b1); k++) @(negedge i_core_clk);
    check_val({7'h00, spoint}, 8'h01, "sample point");
    rx = 1'b0;
    @(negedge i_core_clk);
    rx = 1'b1;
    check_val({7'h00, sbit}, {7'h00, triple}, "sampled bit");
    $display("sampling case done");
  endtask : sample_case
  // Late edge at the start of phase two shortens it by the jump width
  task automatic late_edge_case();
    int k;
    host_u.write_reg(8'h2A, 8'h47);
    host_u.write_reg(8'h29, 8'h80);
    host_u.write_reg(8'h28, 8'h07);
    repeat (2) wait_start();
    for (k = 0; k < 2000 && seg !== 2'b10; k++) @(negedge i_core_clk);
    rx = 1'b0;
    for (k = 0; k < 2000 && bstart !== 1'b1; k++) begin
      @(negedge i_core_clk);
      rx = 1'b1;
    end
    check_cnt(k + 1, 96, "shortened phase two clocks");
    $display("late edge case done");
  endtask : late_edge_case
  initial begin
    int r;
    repeat (20) @(negedge i_core_clk);
    i_resetn = 1'b1;
    check_val({3'h0, sof_sel, wake, sbit, seg}, 8'h04, "reset outputs");
    for (r = 0; r < 3; r++) begin
      host_u.read_reg(8'h2A - r[7:0], got);
      check_val(got, 8'h00, "reset value");
    end
    $display("reset test done");
    for (r = 0; r < 6; r++) begin
      cm = ROWS[r][24];
      host_u.write_reg(ROWS[r][23:16], ROWS[r][15:8]);
      host_u.read_reg(ROWS[r][23:16], got);
      check_val(got, ROWS[r][7:0], "read-back");
    end
    cm = 1'b1;
    $display("register rows done");
    for (r = 0; r < 4; r++) begin
      host_u.write_reg(8'h28, r[1] ? 8'h07 : 8'hC7);
      clk_en = r[0];
      @(negedge i_core_clk);
      check_val({6'h00, sof_sel, div_sel}, {6'h00, r[0] & ~r[1], r[0] & r[1]}, "clock out select");
      check_val({7'h00, wake}, {7'h00, ~r[1]}, "wake filter");
    end
    $display("select test done");
    timing_case(1'b1, 8'h00, 8'h00, 8'h01, 1, 1, 2, 2);
    timing_case(1'b1, 8'h01, 8'h2A, 8'h07, 3, 6, 6, 4);
    timing_case(1'b1, 8'hC3, 8'h87, 8'h04, 8, 1, 5, 8);
    timing_case(1'b1, 8'h3F, 8'h00, 8'h01, 1, 1, 2, 128);
    timing_case(1'b0, 8'h00, 8'h87, 8'h04, 1, 1, 2, 128);
    host_u.write_reg(8'h2A, 8'h07);
    sample_case(1'b0);
    sample_case(1'b1);
    late_edge_case();
    complete_run();
  end
endmodule : can_bit_timing_config_bench
bind can_bit_timing_config can_bit_timing_checker chk_u (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
  .i_reg_addr(i_reg_addr), .i_reg_write(i_reg_write), .i_reg_wdata(i_reg_wdata), .i_reg_read(i_reg_read),
  .o_reg_rdata(o_reg_rdata), .i_config_mode(i_config_mode), .i_clock_output_enable(i_clock_output_enable),
  .i_bus_receive_pin(i_bus_receive_pin), .o_clock_output_sof_select(o_clock_output_sof_select),
  .o_clock_output_divided_select(o_clock_output_divided_select),
  .o_wakeup_glitch_filter_enable(o_wakeup_glitch_filter_enable), .o_quantum_tick(o_quantum_tick),
  .o_bit_start(o_bit_start), .o_sample_point(o_sample_point), .o_sampled_bit(o_sampled_bit),
  .o_segment(o_segment));
`default_nettype wire
